// >>> src/rcs_decoder.sv
// Radio command strobe decoder: SPI access, registers, strobes, radio state
// Assumes an SPI mode 0 master, FIFOs and modem on i_clock outside
`timescale 1ns/1ps
`include "rcs_defines.svh"
module rcs_decoder #(
   parameter int unsigned CAL_CYC   = `RCS_CAL_US * `RCS_CLK_MHZ,
   parameter int unsigned CAL_Q_CYC = `RCS_CALQ_US * `RCS_CLK_MHZ
) (
   // Clock and reset
   input  wire logic              i_clock,
   input  wire logic              i_rst,
   // SPI pins
   input  wire logic              i_sclk,
   input  wire logic              i_chip_select_n,
   input  wire logic              i_si,
   output logic                   o_so,
   output logic                   o_so_oe,
   // FIFO side
   output logic                   o_tx_wr,
   output logic [7:0]             o_tx_data,
   output logic                   o_rx_rd,
   input  wire logic [7:0]        i_rx_data,
   input  wire logic [6:0]        i_tx_count,
   input  wire logic [6:0]        i_rx_count,
   input  wire logic              i_tx_underflow,
   input  wire logic              i_rx_overflow,
   output logic                   o_tx_flush,
   output logic                   o_rx_flush,
   // Modem
   input  wire logic              i_channel_clear,
   input  wire logic [7:0]        i_rssi,
   input  wire logic [7:0]        i_lqi,
   // Radio state
   output rcs_pkg::rcs_state_t    o_radio_state
);
   import rcs_pkg::*;

   // ==================================================
   // Link domain: shift bytes in on SCLK, reset while deselected
   logic [2:0] bit_reg;
   logic [6:0] shin_reg;
   logic [7:0] byte_reg;
   logic       tgl_reg;
   logic [7:0] resp_reg;

   always_ff @(posedge i_sclk or posedge i_chip_select_n) begin
      if (i_chip_select_n) begin
         bit_reg  <= 3'h0;
         shin_reg <= 7'h00;
         byte_reg <= 8'h00;
         tgl_reg  <= 1'b0;
      end else begin
         bit_reg  <= bit_reg + 3'h1;
         shin_reg <= {shin_reg[5:0], i_si};
         if (bit_reg == 3'h7) begin
            byte_reg <= {shin_reg, i_si};
            tgl_reg  <= ~tgl_reg;
         end
      end
   end

   // Answer byte is held still by the system side while the host clocks
   assign o_so    = resp_reg[3'h7 - bit_reg];
   assign o_so_oe = ~i_chip_select_n;

   // ==================================================
   // Crossing into the system clock
   logic cs1_reg, cs2_reg, csd_reg;
   logic t1_reg, t2_reg, t3_reg, t4_reg;

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         cs1_reg <= 1'b1;
         cs2_reg <= 1'b1;
         csd_reg <= 1'b1;
         t1_reg  <= 1'b0;
         t2_reg  <= 1'b0;
         t3_reg  <= 1'b0;
         t4_reg  <= 1'b0;
      end else begin
         cs1_reg <= i_chip_select_n;
         cs2_reg <= cs1_reg;
         csd_reg <= cs2_reg;
         t1_reg  <= tgl_reg;
         t2_reg  <= t1_reg;
         t3_reg  <= t2_reg;
         t4_reg  <= t3_reg;
      end
   end

   // Extra toggle stage lets deselect win over the toggle reset
   wire cs_hi    = cs2_reg;
   // Wake on a fresh select only, never on the select of the strobe's own frame
   wire cs_fall  = csd_reg & ~cs2_reg;
   wire byte_evt = (t3_reg ^ t4_reg) & ~cs_hi;

   // ==================================================
   // Header decode
   logic       first_reg, live_reg, load_reg;
   logic       acc_rw_reg, acc_burst_reg;
   logic [5:0] acc_addr_reg;

   wire       hdr_rw    = byte_reg[`RCS_RW_BIT];
   wire       hdr_burst = byte_reg[`RCS_BURST_BIT];
   wire [5:0] hdr_addr  = byte_reg[`RCS_ADDR_MSB:0];
   wire       hdr_evt   = byte_evt & first_reg;
   wire       hdr_hi    = hdr_addr > `RCS_CFG_LAST;
   // Above the configuration space a read burst selects status registers
   wire       hdr_stat  = hdr_hi & hdr_rw & hdr_burst;
   wire       hdr_strb  = hdr_addr >= `RCS_STRB_FIRST & hdr_addr <= `RCS_STRB_LAST
                          & ~hdr_stat;
   wire       hdr_fifo  = hdr_addr == `RCS_FIFO_ADDR;
   wire       hdr_bst   = hdr_burst & (~hdr_hi | hdr_fifo);
   wire       strb      = hdr_evt & hdr_strb;

   wire s_reset  = strb & hdr_addr == `RCS_CHIP_RESET_STROBE;
   wire s_fson   = strb & hdr_addr == `RCS_SYNTH_ON_STROBE;
   wire s_xoff   = strb & hdr_addr == `RCS_OSC_OFF_STROBE;
   wire s_cal    = strb & hdr_addr == `RCS_SYNTH_CAL_STROBE;
   wire s_rx     = strb & hdr_addr == `RCS_RECEIVE_STROBE;
   wire s_tx     = strb & hdr_addr == `RCS_TRANSMIT_STROBE;
   wire s_idle   = strb & hdr_addr == `RCS_IDLE_STROBE;
   wire s_wor    = strb & hdr_addr == `RCS_WAKE_POLL_STROBE;
   wire s_pwd    = strb & hdr_addr == `RCS_POWER_DOWN_STROBE;
   wire s_rxfl   = strb & hdr_addr == `RCS_RX_FLUSH_STROBE;
   wire s_txfl   = strb & hdr_addr == `RCS_TX_FLUSH_STROBE;
   wire s_wrld   = strb & hdr_addr == `RCS_WAKE_RELOAD_STROBE;
   wire s_nop    = strb & hdr_addr == `RCS_NO_OP_STROBE;
   wire chip_rst = i_rst | s_reset;

   // ==================================================
   // Data byte handling
   wire data_evt = byte_evt & ~first_reg & live_reg;
   wire acc_fifo = acc_addr_reg == `RCS_FIFO_ADDR;
   wire wr_cfg   = data_evt & ~acc_rw_reg & acc_addr_reg <= `RCS_CFG_LAST;

   assign o_tx_wr   = data_evt & ~acc_rw_reg & acc_fifo;
   assign o_tx_data = byte_reg;
   assign o_rx_rd   = data_evt & acc_rw_reg & acc_fifo;

   always_ff @(posedge i_clock) begin
      if (i_rst | cs_hi) begin
         first_reg     <= 1'b1;
         live_reg      <= 1'b0;
         load_reg      <= 1'b0;
         acc_rw_reg    <= 1'b0;
         acc_burst_reg <= 1'b0;
         acc_addr_reg  <= 6'h00;
      end else begin
         load_reg <= byte_evt;
         if (hdr_evt) begin
            first_reg     <= 1'b0;
            live_reg      <= ~hdr_strb;
            acc_rw_reg    <= hdr_rw;
            acc_burst_reg <= hdr_bst;
            acc_addr_reg  <= hdr_addr;
         end else if (data_evt) begin
            live_reg <= acc_burst_reg;
            if (~acc_fifo)
               acc_addr_reg <= acc_addr_reg + 6'h01;
         end
      end
   end

   // ==================================================
   // Configuration registers
   logic [7:0] cfg_reg [0:`RCS_CFG_LAST];
   rcs_state_t st_reg, st_next, tgt_reg, tgt_next;
   wire enter_sleep = st_next == RCS_SLEEP & st_reg != RCS_SLEEP;

   always_ff @(posedge i_clock) begin
      for (int i = 0; i <= `RCS_CFG_LAST; i++) begin
         if (chip_rst)
            cfg_reg[i] <= `RCS_CFG_RST;
         else if (enter_sleep & i >= `RCS_TEST_FIRST)
            cfg_reg[i] <= `RCS_CFG_RST;
         else if (wr_cfg & acc_addr_reg == 6'(i))
            cfg_reg[i] <= byte_reg;
      end
   end

   wire [7:0] mcsm0  = cfg_reg[`RCS_MCSM0];
   wire [7:0] mcsm1  = cfg_reg[`RCS_MCSM1];
   wire [7:0] synth_cal_pump = cfg_reg[`RCS_SYNTH_CAL_PUMP];
   wire       autocal = mcsm0[5:4] == `RCS_AUTOCAL_ON;
   wire       cca     = mcsm1[5:4] != `RCS_CCA_OFF;
   wire       rc_osc_powerdown   = cfg_reg[`RCS_WORCTRL][`RCS_RC_OSC_POWERDOWN_BIT];
   wire       pump_skip = synth_cal_pump[5:4] == `RCS_PUMP_SKIP;
   wire [15:0] evt_one = {cfg_reg[`RCS_WOREVT1], cfg_reg[`RCS_WOREVT0]};

   // ==================================================
   // Radio control state machine
   logic [`RCS_CALW-1:0] cal_reg;
   logic                 pwd_reg;
   logic                 cal_go;

   always_comb begin
      st_next  = st_reg;
      tgt_next = tgt_reg;
      cal_go   = 1'b0;
      if (s_idle) begin
         st_next = RCS_IDLE;
      end else begin
         case (st_reg)
            RCS_IDLE: begin
               if (s_cal) begin
                  cal_go   = 1'b1;
                  tgt_next = RCS_IDLE;
               end else if (s_rx | s_tx | s_fson) begin
                  tgt_next = s_rx ? RCS_RX : (s_tx ? RCS_TX : RCS_FSON);
                  cal_go   = autocal;
                  st_next  = tgt_next;
               end else if (s_xoff) begin
                  st_next = RCS_XOFF;
               end else if (s_wor & ~rc_osc_powerdown) begin
                  st_next = RCS_WOR;
               end else if (pwd_reg & cs_hi) begin
                  st_next = RCS_SLEEP;
               end
            end
            RCS_CAL: begin
               if (cal_reg == '0)
                  st_next = tgt_reg;
            end
            RCS_RX: begin
               if (i_rx_overflow)
                  st_next = RCS_RXOVF;
               else if (s_tx & (~cca | i_channel_clear))
                  st_next = RCS_TX;
               else if (s_fson & cca)
                  st_next = RCS_FSON;
            end
            RCS_TX: begin
               if (i_tx_underflow)
                  st_next = RCS_TXUNF;
               else if (s_rx)
                  st_next = RCS_RX;
            end
            RCS_FSON: begin
               if (s_tx)
                  st_next = RCS_TX;
               else if (s_rx)
                  st_next = RCS_RX;
            end
            RCS_RXOVF: begin
               if (s_rxfl)
                  st_next = RCS_IDLE;
            end
            RCS_TXUNF: begin
               if (s_txfl)
                  st_next = RCS_IDLE;
            end
            RCS_XOFF, RCS_SLEEP: begin
               if (cs_fall)
                  st_next = RCS_IDLE;
            end
            RCS_WOR: st_next = RCS_WOR;
            default: st_next = RCS_IDLE;
         endcase
      end
      if (cal_go)
         st_next = RCS_CAL;
   end

   always_ff @(posedge i_clock) begin
      if (chip_rst) begin
         st_reg  <= RCS_IDLE;
         tgt_reg <= RCS_IDLE;
         cal_reg <= '0;
         pwd_reg <= 1'b0;
      end else begin
         st_reg  <= st_next;
         tgt_reg <= tgt_next;
         if (cal_go)
            cal_reg <= pump_skip ? `RCS_CALW'(CAL_Q_CYC - 1)
                                 : `RCS_CALW'(CAL_CYC - 1);
         else if (cal_reg != '0)
            cal_reg <= cal_reg - `RCS_CALW'(1);
         if (enter_sleep)
            pwd_reg <= 1'b0;
         else if (s_pwd)
            pwd_reg <= 1'b1;
      end
   end

   assign o_radio_state = st_reg;
   assign o_rx_flush = s_rxfl & (st_reg == RCS_IDLE | st_reg == RCS_RXOVF);
   assign o_tx_flush = s_txfl & (st_reg == RCS_IDLE | st_reg == RCS_TXUNF);

   // ==================================================
   // Wake-on-radio timer
   logic [15:0] wtmr_reg;

   always_ff @(posedge i_clock) begin
      if (chip_rst)
         wtmr_reg <= 16'h0000;
      else if (s_wrld | (st_reg == RCS_WOR & wtmr_reg == 16'h0000))
         wtmr_reg <= evt_one;
      else if (st_reg == RCS_WOR)
         wtmr_reg <= wtmr_reg - 16'h0001;
   end

   // ==================================================
   // Status byte and read data
   logic [2:0] code;

   always_comb begin
      case (st_reg)
         RCS_RX:    code = `RCS_CODE_RX;
         RCS_TX:    code = `RCS_CODE_TX;
         RCS_FSON:  code = `RCS_CODE_FSON;
         RCS_CAL:   code = `RCS_CODE_CAL;
         RCS_RXOVF: code = `RCS_CODE_RXOVF;
         RCS_TXUNF: code = `RCS_CODE_TXUNF;
         default:   code = `RCS_CODE_IDLE;
      endcase
   end

   wire [6:0] fcount = acc_rw_reg ? i_rx_count : i_tx_count;
   wire [3:0] avail  = fcount > `RCS_AVAIL_MAX ? 4'hf : fcount[3:0];
   wire osc_off = st_reg == RCS_XOFF | st_reg == RCS_SLEEP;
   wire [7:0] status = {osc_off, code, avail};
   logic [7:0] rd_stat;

   // Status registers have no storage, so writes cannot reach them
   always_comb begin
      case (acc_addr_reg)
         `RCS_PART_ADDR:    rd_stat = `RCS_PART_ID;
         `RCS_VER_ADDR:     rd_stat = `RCS_VERSION_ID;
         `RCS_LQI_ADDR:     rd_stat = i_lqi;
         `RCS_RSSI_ADDR:    rd_stat = i_rssi;
         `RCS_STATE_ADDR:   rd_stat = {5'h00, code};
         `RCS_WTIME1_ADDR:  rd_stat = wtmr_reg[15:8];
         `RCS_WTIME0_ADDR:  rd_stat = wtmr_reg[7:0];
         `RCS_TXBYTES_ADDR: rd_stat = {i_tx_underflow, i_tx_count};
         `RCS_RXBYTES_ADDR: rd_stat = {i_rx_overflow, i_rx_count};
         default:           rd_stat = 8'h00;
      endcase
   end

   wire [7:0] rd_val = acc_fifo ? i_rx_data
                     : (acc_addr_reg <= `RCS_CFG_LAST ? cfg_reg[acc_addr_reg] : rd_stat);
   wire       rd_now = acc_rw_reg & live_reg;

   always_ff @(posedge i_clock) begin
      if (i_rst | cs_hi)
         resp_reg <= status;
      else if (load_reg)
         resp_reg <= rd_now ? rd_val : status;
   end

   // ==================================================
   // Assertions
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_rst);

   property p_idle_strobe;
      s_idle |=> st_reg == RCS_IDLE;
   endproperty
   a_idle_strobe: assert property (p_idle_strobe) else $error("idle strobe ignored");

   property p_rx_autocal;
      s_rx & st_reg == RCS_IDLE & autocal |=> st_reg == RCS_CAL & tgt_reg == RCS_RX;
   endproperty
   a_rx_autocal: assert property (p_rx_autocal) else $error("receive skipped cal");

   property p_cal_hold;
      st_reg == RCS_CAL & cal_reg != '0 & ~s_idle & ~s_reset |=> st_reg == RCS_CAL;
   endproperty
   a_cal_hold: assert property (p_cal_hold) else $error("calibration cut short");

   property p_cal_len;
      cal_go & ~pump_skip |=> cal_reg == `RCS_CALW'(CAL_CYC - 1);
   endproperty
   a_cal_len: assert property (p_cal_len) else $error("wrong calibration length");

   property p_sleep_cs;
      $rose(st_reg == RCS_SLEEP) |-> $past(cs_hi) & $past(pwd_reg);
   endproperty
   a_sleep_cs: assert property (p_sleep_cs) else $error("early power down");

   property p_wor_rc;
      $rose(st_reg == RCS_WOR) |-> $past(s_wor) & ~$past(rc_osc_powerdown);
   endproperty
   a_wor_rc: assert property (p_wor_rc) else $error("wake polling with rc off");

   property p_nop;
      s_nop & st_reg != RCS_CAL & st_reg != RCS_SLEEP & ~i_rx_overflow
         & ~i_tx_underflow & ~(pwd_reg & cs_hi) |=> $stable(st_reg);
   endproperty
   a_nop: assert property (p_nop) else $error("no-op changed state");

   property p_reload;
      s_wrld |=> wtmr_reg == $past(evt_one);
   endproperty
   a_reload: assert property (p_reload) else $error("wake timer not reloaded");

   property p_flush;
      o_rx_flush & st_reg == RCS_RXOVF & ~s_idle |=> st_reg == RCS_IDLE;
   endproperty
   a_flush: assert property (p_flush) else $error("overflow not left");

   property p_tx_cca;
      s_tx & st_reg == RCS_RX & cca & ~i_channel_clear & ~i_rx_overflow |=> st_reg == RCS_RX;
   endproperty
   a_tx_cca: assert property (p_tx_cca) else $error("transmit on busy channel");

   property p_c_cal_rx;
      st_reg == RCS_CAL ##1 st_reg == RCS_RX;
   endproperty
   c_cal_rx: cover property (p_c_cal_rx);

   property p_c_cfg_wr;
      wr_cfg ##1 load_reg;
   endproperty
   c_cfg_wr: cover property (p_c_cfg_wr);

   property p_c_sleep;
      st_reg == RCS_SLEEP ##1 st_reg == RCS_IDLE;
   endproperty
   c_sleep: cover property (p_c_sleep);
endmodule : rcs_decoder

// >>> src/rcs_defines.svh
// Constants of the radio command strobe decoder: timing, address map, fields
// Included by the decoder and the bench; definitions only
`ifndef RCS_DEFINES_SVH
`define RCS_DEFINES_SVH
// ==================================================
// Timing
`define RCS_CLK_MHZ       100
`define RCS_CAL_US        720
`define RCS_CALQ_US       150
`define RCS_CALW          17
// ==================================================
// Header byte layout
`define RCS_RW_BIT        7
`define RCS_BURST_BIT     6
`define RCS_ADDR_MSB      5
// ==================================================
// Address map
`define RCS_CFG_LAST      6'h2e
`define RCS_TEST_FIRST    6'h29
`define RCS_STAT_FIRST    6'h30
`define RCS_STAT_LAST     6'h3b
`define RCS_STRB_FIRST    6'h30
`define RCS_STRB_LAST     6'h3d
`define RCS_FIFO_ADDR     6'h3f
`define RCS_CFG_RST       8'h00
// ==================================================
// Command strobes
`define RCS_CHIP_RESET_STROBE   6'h30
`define RCS_SYNTH_ON_STROBE     6'h31
`define RCS_OSC_OFF_STROBE      6'h32
`define RCS_SYNTH_CAL_STROBE    6'h33
`define RCS_RECEIVE_STROBE      6'h34
`define RCS_TRANSMIT_STROBE     6'h35
`define RCS_IDLE_STROBE         6'h36
`define RCS_WAKE_POLL_STROBE    6'h38
`define RCS_POWER_DOWN_STROBE   6'h39
`define RCS_RX_FLUSH_STROBE     6'h3a
`define RCS_TX_FLUSH_STROBE     6'h3b
`define RCS_WAKE_RELOAD_STROBE  6'h3c
`define RCS_NO_OP_STROBE        6'h3d
// ==================================================
// Status register addresses (read with burst bit set)
`define RCS_PART_ADDR     6'h30
`define RCS_VER_ADDR      6'h31
`define RCS_LQI_ADDR      6'h33
`define RCS_RSSI_ADDR     6'h34
`define RCS_STATE_ADDR    6'h35
`define RCS_WTIME1_ADDR   6'h36
`define RCS_WTIME0_ADDR   6'h37
`define RCS_TXBYTES_ADDR  6'h3a
`define RCS_RXBYTES_ADDR  6'h3b
// Identity values are arbitrary
`define RCS_PART_ID       8'h5a
`define RCS_VERSION_ID    8'h01
// ==================================================
// Configuration fields
`define RCS_WOREVT1       6'h1e
`define RCS_WOREVT0       6'h1f
`define RCS_MCSM1         6'h17
`define RCS_MCSM0         6'h18
`define RCS_WORCTRL       6'h20
`define RCS_SYNTH_CAL_PUMP        6'h23
`define RCS_AUTOCAL_ON    2'h1
`define RCS_CCA_OFF       2'h0
`define RCS_PUMP_SKIP     2'h0
`define RCS_RC_OSC_POWERDOWN_BIT     7
// ==================================================
// Chip status byte state codes
`define RCS_CODE_IDLE     3'h0
`define RCS_CODE_RX       3'h1
`define RCS_CODE_TX       3'h2
`define RCS_CODE_FSON     3'h3
`define RCS_CODE_CAL      3'h4
`define RCS_CODE_RXOVF    3'h6
`define RCS_CODE_TXUNF    3'h7
`define RCS_AVAIL_MAX     7'h0f
`endif

// >>> src/rcs_pkg.sv
// Types of the radio command strobe decoder
// Constants live in rcs_defines.svh
package rcs_pkg;
   // ==================================================
   // Radio control state, one-hot
   typedef enum logic [9:0] {
      RCS_IDLE  = 10'h001,
      RCS_CAL   = 10'h002,
      RCS_RX    = 10'h004,
      RCS_TX    = 10'h008,
      RCS_FSON  = 10'h010,
      RCS_RXOVF = 10'h020,
      RCS_TXUNF = 10'h040,
      RCS_XOFF  = 10'h080,
      RCS_SLEEP = 10'h100,
      RCS_WOR   = 10'h200
   } rcs_state_t;
endpackage : rcs_pkg

// >>> tb/radio_command_strobe_decoder_tb_top.sv
// Self-checking bench for the radio command strobe decoder
// Assumes rcs_spi_host drives the SPI pins; FIFO and modem are stubs here
`timescale 1ns/1ps
`include "rcs_defines.svh"
module radio_command_strobe_decoder_tb_top;
   import rcs_pkg::*;
   logic       clock, rst, sclk, cs_n, si, so, tx_wr, tx_flush, rx_flush, clear;
   logic       rx_rd, ovf, unf;
   logic [7:0] tx_data, rssi, st, rd, last_tx;
   logic [6:0] tx_count;
   rcs_state_t state;
   int         failures, n_tests, n_rxf, n_txf, n_rd;
   rcs_decoder #(.CAL_CYC(200), .CAL_Q_CYC(80)) dut_u (
      .i_clock(clock), .i_rst(rst), .i_sclk(sclk), .i_chip_select_n(cs_n), .i_si(si),
      .o_so(so), .o_so_oe(), .o_tx_wr(tx_wr), .o_tx_data(tx_data), .o_rx_rd(rx_rd),
      .i_rx_data(8'h96), .i_tx_count(tx_count), .i_rx_count(7'h00),
      .i_tx_underflow(unf), .i_rx_overflow(ovf), .o_tx_flush(tx_flush),
      .o_rx_flush(rx_flush), .i_channel_clear(clear), .i_rssi(rssi), .i_lqi(8'h00),
      .o_radio_state(state));
   rcs_spi_host host_u (.o_sclk(sclk), .o_chip_select_n(cs_n), .o_si(si), .i_so(so));
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   always @(negedge clock) begin
      if (rx_flush === 1'b1) n_rxf++;
      if (tx_flush === 1'b1) n_txf++;
      if (tx_wr === 1'b1) last_tx = tx_data;
      if (rx_rd === 1'b1) n_rd++;
   end
   // ==================================================
   // Shared helpers
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic wrap_up();
      $display("checks %0d failures %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : wrap_up
   task automatic acc(input logic [7:0] hdr, input logic [7:0] dat, input bit two);
      host_u.frame(hdr, dat, two, st, rd);
   endtask : acc
   task automatic wait_state(input rcs_state_t s, input int lim);
      int k;
      k = 0;
      while (state !== s && k < lim) begin
         @(negedge clock);
         k++;
      end
      chk("state", 16'(state), 16'(s));
      if (state !== s)
         wrap_up();
   endtask : wait_state
   // ==================================================
   // Scenarios
   task automatic t_basic();
      acc(8'h3d, 8'h00, 0);
      chk("status", 16'(st), 16'h03);
      chk("reset state", 16'(state), 16'(RCS_IDLE));
      acc(8'h05, 8'ha5, 1);
      chk("hdr status", 16'(st), 16'h03);
      chk("wr status", 16'(rd), 16'h03);
      acc(8'h85, 8'h00, 1);
      chk("cfg", 16'(rd), 16'ha5);
      acc(8'hf4, 8'h00, 1);
      chk("rssi", 16'(rd), 16'(rssi));
      acc(8'hf0, 8'h00, 1);
      chk("part", 16'(rd), 16'(`RCS_PART_ID));
      acc(8'h3f, 8'h5b, 1);
      chk("tx fifo", 16'(last_tx), 16'h5b);
      acc(8'hbf, 8'h00, 1);
      chk("rx fifo", 16'(rd), 16'h96);
      chk("rx pop", 16'(n_rd), 16'h01);
      $display("basic done");
   endtask : t_basic
   task automatic t_hop(input logic [7:0] pump, input int hold, input int lim);
      acc(8'h23, pump, 1);
      acc(8'h36, 8'h00, 0);
      acc(8'h34, 8'h00, 0);
      chk("cal", 16'(state), 16'(RCS_CAL));
      repeat (hold) @(negedge clock);
      chk("cal hold", 16'(state), 16'(RCS_CAL));
      wait_state(RCS_RX, lim);
      $display("hop done");
   endtask : t_hop
   task automatic t_tx();
      acc(8'h17, 8'h10, 1);
      acc(8'h35, 8'h00, 0);
      chk("busy chan", 16'(state), 16'(RCS_RX));
      @(negedge clock) clear = 1'b1;
      acc(8'h35, 8'h00, 0);
      chk("tx", 16'(state), 16'(RCS_TX));
      acc(8'h3a, 8'h00, 0);
      chk("flush in tx", 16'(n_rxf), 16'h00);
      acc(8'h36, 8'h00, 0);
      chk("idle", 16'(state), 16'(RCS_IDLE));
      acc(8'h3a, 8'h00, 0);
      acc(8'h3b, 8'h00, 0);
      chk("flushes", {n_rxf[7:0], n_txf[7:0]}, 16'h0101);
      $display("tx done");
   endtask : t_tx
   task automatic t_modes();
      acc(8'h33, 8'h00, 0);
      chk("cal strobe", 16'(state), 16'(RCS_CAL));
      wait_state(RCS_IDLE, 100);
      acc(8'h34, 8'h00, 0);
      wait_state(RCS_RX, 100);
      acc(8'h31, 8'h00, 0);
      chk("synth on", 16'(state), 16'(RCS_FSON));
      acc(8'h36, 8'h00, 0);
      acc(8'h34, 8'h00, 0);
      wait_state(RCS_RX, 100);
      @(negedge clock) ovf = 1'b1;
      @(negedge clock);
      chk("overflow", 16'(state), 16'(RCS_RXOVF));
      acc(8'h3a, 8'h00, 0);
      chk("rx fault flush", 16'(state), 16'(RCS_IDLE));
      @(negedge clock) ovf = 1'b0;
      acc(8'h35, 8'h00, 0);
      wait_state(RCS_TX, 100);
      @(negedge clock) unf = 1'b1;
      @(negedge clock);
      chk("underflow", 16'(state), 16'(RCS_TXUNF));
      acc(8'h3b, 8'h00, 0);
      chk("tx fault flush", 16'(state), 16'(RCS_IDLE));
      @(negedge clock) unf = 1'b0;
      acc(8'h1e, 8'h12, 1);
      acc(8'h1f, 8'h34, 1);
      acc(8'h3c, 8'h00, 0);
      acc(8'hf6, 8'h00, 1);
      chk("wake timer", 16'(rd), 16'h12);
      acc(8'h38, 8'h00, 0);
      chk("wake poll", 16'(state), 16'(RCS_WOR));
      acc(8'h36, 8'h00, 0);
      chk("poll stop", 16'(state), 16'(RCS_IDLE));
      acc(8'h20, 8'h80, 1);
      acc(8'h38, 8'h00, 0);
      chk("rc off", 16'(state), 16'(RCS_IDLE));
      $display("modes done");
   endtask : t_modes
   task automatic t_power();
      acc(8'h2e, 8'h77, 1);
      acc(8'h39, 8'h00, 0);
      chk("sleep", 16'(state), 16'(RCS_SLEEP));
      acc(8'hae, 8'h00, 1);
      chk("test reg", 16'(rd), 16'h00);
      acc(8'h32, 8'h00, 0);
      chk("xoff", 16'(state), 16'(RCS_XOFF));
      acc(8'h30, 8'h00, 0);
      acc(8'h85, 8'h00, 1);
      chk("reset cfg", 16'(rd), 16'h00);
      $display("power done");
   endtask : t_power
   // ==================================================
   // Main sequence
   initial begin
      rst = 1'b1;
      clear = 1'b0;
      tx_count = 7'h03;
      rssi = 8'h4c;
      last_tx = 8'h00;
      failures = 0;
      n_tests = 0;
      n_rxf = 0;
      n_txf = 0;
      n_rd = 0;
      ovf = 1'b0;
      unf = 1'b0;
      repeat (10) @(negedge clock);
      rst = 1'b0;
      repeat (5) @(negedge clock);
      t_basic();
      acc(8'h18, 8'h10, 1);
      t_hop(8'h20, 150, 100);
      t_hop(8'h00, 20, 60);
      t_tx();
      t_modes();
      t_power();
      wrap_up();
   end
endmodule : radio_command_strobe_decoder_tb_top

// >>> tb/rcs_spi_host.sv
// SPI host model for the strobe decoder: mode 0, MSB first, 15 ns sclk
// Assumes the bench calls frame() from one process at a time
`timescale 1ns/1ps
module rcs_spi_host (
   // SPI pins
   output logic      o_sclk,
   output logic      o_chip_select_n,
   output logic      o_si,
   input  wire logic i_so
);
   // A clean rising select at start clears the decoder's link shifter
   initial begin
      o_sclk = 1'b0;
      o_chip_select_n = 1'b0;
      o_si = 1'b0;
      #1;
      o_chip_select_n = 1'b1;
   end
   // ==================================================
   // One byte, then a quiet gap so the answer can settle
   task automatic xbyte(input logic [7:0] d, output logic [7:0] q);
      for (int i = 7; i >= 0; i--) begin
         o_si = d[i];
         #7.5;
         q[i] = i_so;
         o_sclk = 1'b1;
         #7.5;
         o_sclk = 1'b0;
      end
      o_si = ~d[0];
      #200;
   endtask : xbyte
   // ==================================================
   // Header plus optional data byte in one select window
   task automatic frame(input logic [7:0] hdr, input logic [7:0] dat, input bit two,
                        output logic [7:0] st, output logic [7:0] rd);
      rd = 8'h00;
      o_chip_select_n = 1'b0;
      #100;
      xbyte(hdr, st);
      if (two)
         xbyte(dat, rd);
      o_chip_select_n = 1'b1;
      #100;
   endtask : frame
endmodule : rcs_spi_host
